// ==== core/wave_map.svh ====
// Offsets, field positions and reset values of the waveform block.
// Assumes it is included by bare name from core files only.
`ifndef WAVE_MAP_SVH
`define WAVE_MAP_SVH
`define ACS_OFFSET       8'hd8
`define ACS_RESET        8'h00
`define ACS_CF_BIT       7
`define ACS_CR_BIT       6
`define CMR_OFFSET       8'hd9
`define CMR_RESET        8'h40
`define CMR_TB_LSB       1
`define MMR_BASE         8'hda
`define CPL_BASE         8'he0
`define CPH_BASE         8'he8
`define MMR_RESET        8'h00
`define MMR_PWM16_BIT    7
`define MMR_ECOM_BIT     6
`define MMR_TOG_BIT      2
`define MMR_PWM_BIT      1
`define TB_DIV12         3'h0
`define TB_DIV4          3'h1
`define TB_SYSCLK        3'h4
`define DIV12_COUNT      4'hb
`define DIV4_COUNT       4'h3
`endif

// ==== core/wave_pkg.sv ====
// Types for the waveform block.
// Assumes nothing beyond a SystemVerilog compiler.
package wave_pkg;
   typedef enum logic [3:0] {
      MODE_OFF   = 4'b0001,
      MODE_FREQ  = 4'b0010,
      MODE_PWM8  = 4'b0100,
      MODE_PWM16 = 4'b1000
   } wave_mode_e;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;
endpackage

// ==== core/wave_array.sv ====
// Counter array with per-module waveform outputs and special function registers.
// Assumes a single-cycle register port driven from core_clk logic; no pins need sync.
//
// Summary of operation
// - Square wave toggles every high-byte counter clocks
// - High byte zero means 256 clocks
// - Low byte match toggles, adds high byte
// - Enable, toggle, pulse bits select square wave
// - 8-bit pulse: low byte match drives high
// - 8-bit pulse: low byte overflow drives low
// - Low byte wrap reloads compare low byte
// - Enable, pulse, not toggle, not wide select 8-bit pulse
// - Low write clears enable, high sets
// - 8-bit duty is (256-high)/256
// - Enable clear holds pulse-mode output low
// - 16-bit: match high, overflow low
// - Enable, pulse, wide, not toggle bits select 16-bit
// - 16-bit duty is (65536-word)/65536
// - Match sets sticky module event flag
// - Counter wrap sets sticky overflow flag
// - Timebase field picks counter clock rate
`include "wave_map.svh"
module wave_array #(
   parameter int NMOD = 5
) (
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   input  wire wave_pkg::sfr_req_s  sfr_req,
   input  wire logic                timer0_ovf,
   output logic [7:0]               sfr_rdata,
   output logic [NMOD-1:0]          module_output_pin
);
   // ***********************************************************
   // Registers
   // ***********************************************************
   logic [7:0]      acs_r, acs_nxt;
   logic [7:0]      cmr_r, cmr_nxt;
   logic [15:0]     cnt_r, cnt_nxt;
   logic [3:0]      pre_r, pre_nxt;
   logic [7:0]      mmr_r [NMOD], mmr_nxt [NMOD];
   logic [7:0]      cpl_r [NMOD], cpl_nxt [NMOD];
   logic [7:0]      cph_r [NMOD], cph_nxt [NMOD];
   logic [NMOD-1:0] pin_r, pin_nxt;
   logic [7:0]      rd_r, rd_nxt;
   logic            tick;

   function automatic wave_pkg::wave_mode_e decode_mode(input logic [7:0] m);
      if (!m[`MMR_ECOM_BIT] || !m[`MMR_PWM_BIT])
         decode_mode = wave_pkg::MODE_OFF;
      else if (m[`MMR_TOG_BIT])
         decode_mode = wave_pkg::MODE_FREQ;
      else if (m[`MMR_PWM16_BIT])
         decode_mode = wave_pkg::MODE_PWM16;
      else
         decode_mode = wave_pkg::MODE_PWM8;
   endfunction

   // ***********************************************************
   // Timebase and counter
   // ***********************************************************
   always_comb begin
      logic [2:0] tb;
      tb      = cmr_r[`CMR_TB_LSB +: 3];
      pre_nxt = pre_r;
      tick    = 1'b0;
      if (acs_r[`ACS_CR_BIT]) begin
         case (tb)
            `TB_DIV12, `TB_DIV4: begin
               if (pre_r == ((tb == `TB_DIV12) ? `DIV12_COUNT : `DIV4_COUNT)) begin
                  pre_nxt = 4'h0;
                  tick    = 1'b1;
               end else begin
                  pre_nxt = pre_r + 4'h1;
               end
            end
            `TB_SYSCLK: tick = 1'b1;
            default:    tick = timer0_ovf;
         endcase
      end
      cnt_nxt = tick ? cnt_r + 16'h0001 : cnt_r;
   end

   // ***********************************************************
   // Modules and register port
   // ***********************************************************
   always_comb begin
      wave_pkg::wave_mode_e md;
      logic                 hit;
      logic                 wrap8;
      logic                 wrap16;
      acs_nxt = acs_r;
      cmr_nxt = cmr_r;
      pin_nxt = pin_r;
      rd_nxt  = rd_r;
      md      = wave_pkg::MODE_OFF;
      hit     = 1'b0;
      wrap8   = tick && (cnt_r[7:0] == 8'hff);
      wrap16  = tick && (cnt_r == 16'hffff);
      for (int i = 0; i < NMOD; i++) begin
         mmr_nxt[i] = mmr_r[i];
         cpl_nxt[i] = cpl_r[i];
         cph_nxt[i] = cph_r[i];
      end
      // Software writes come first so hardware sets below win over clears
      if (sfr_req.wr) begin
         if (sfr_req.addr == `ACS_OFFSET)
            acs_nxt = sfr_req.wdata & 8'hdf;
         else if (sfr_req.addr == `CMR_OFFSET)
            cmr_nxt = sfr_req.wdata & 8'h8f;
         for (int i = 0; i < NMOD; i++) begin
            if (sfr_req.addr == `MMR_BASE + 8'(i)) begin
               mmr_nxt[i] = sfr_req.wdata;
            end else if (sfr_req.addr == `CPL_BASE + 8'(i)) begin
               cpl_nxt[i]                = sfr_req.wdata;
               mmr_nxt[i][`MMR_ECOM_BIT] = 1'b0;
            end else if (sfr_req.addr == `CPH_BASE + 8'(i)) begin
               cph_nxt[i]                = sfr_req.wdata;
               mmr_nxt[i][`MMR_ECOM_BIT] = 1'b1;
            end
         end
      end
      if (wrap16)
         acs_nxt[`ACS_CF_BIT] = 1'b1;
      for (int i = 0; i < NMOD; i++) begin
         md = decode_mode(mmr_r[i]);
         case (md)
            wave_pkg::MODE_FREQ: begin
               hit = tick && (cnt_r[7:0] == cpl_r[i]);
               if (hit) begin
                  pin_nxt[i] = ~pin_r[i];
                  // A zero high byte wraps back onto itself: 256 clocks
                  cpl_nxt[i] = cpl_r[i] + cph_r[i];
               end
            end
            wave_pkg::MODE_PWM8: begin
               hit = tick && (cnt_r[7:0] == cpl_r[i]);
               // Match beats wrap, so compare 0 reaches the match at count 0 = 100%
               if (wrap8) begin
                  pin_nxt[i] = 1'b0;
                  cpl_nxt[i] = cph_r[i];
               end
               if (cnt_nxt[7:0] == cpl_nxt[i] && tick)
                  pin_nxt[i] = 1'b1;
            end
            wave_pkg::MODE_PWM16: begin
               hit = tick && (cnt_r == {cph_r[i], cpl_r[i]});
               if (wrap16)
                  pin_nxt[i] = 1'b0;
               if (tick && cnt_nxt == {cph_r[i], cpl_r[i]})
                  pin_nxt[i] = 1'b1;
            end
            default: begin
               hit = 1'b0;
               // Pulse modes with enable cleared give 0% duty
               if (mmr_r[i][`MMR_PWM_BIT] && !mmr_r[i][`MMR_TOG_BIT])
                  pin_nxt[i] = 1'b0;
            end
         endcase
         if (hit)
            acs_nxt[i] = 1'b1;
      end
      if (sfr_req.rd) begin
         rd_nxt = 8'h00;
         if (sfr_req.addr == `ACS_OFFSET)
            rd_nxt = acs_r;
         else if (sfr_req.addr == `CMR_OFFSET)
            rd_nxt = cmr_r;
         for (int i = 0; i < NMOD; i++) begin
            if (sfr_req.addr == `MMR_BASE + 8'(i))
               rd_nxt = mmr_r[i];
            else if (sfr_req.addr == `CPL_BASE + 8'(i))
               rd_nxt = cpl_r[i];
            else if (sfr_req.addr == `CPH_BASE + 8'(i))
               rd_nxt = cph_r[i];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         acs_r <= `ACS_RESET;
         cmr_r <= `CMR_RESET;
         cnt_r <= 16'h0000;
         pre_r <= 4'h0;
         pin_r <= '0;
         rd_r  <= 8'h00;
         for (int i = 0; i < NMOD; i++) begin
            mmr_r[i] <= `MMR_RESET;
            cpl_r[i] <= 8'h00;
            cph_r[i] <= 8'h00;
         end
      end else begin
         acs_r <= acs_nxt;
         cmr_r <= cmr_nxt;
         cnt_r <= cnt_nxt;
         pre_r <= pre_nxt;
         pin_r <= pin_nxt;
         rd_r  <= rd_nxt;
         for (int i = 0; i < NMOD; i++) begin
            mmr_r[i] <= mmr_nxt[i];
            cpl_r[i] <= cpl_nxt[i];
            cph_r[i] <= cph_nxt[i];
         end
      end
   end

   assign sfr_rdata         = rd_r;
   assign module_output_pin = pin_r;
endmodule

// ==== tb/wave_array_props.sv ====
// Port-level checker for the waveform block.
// Assumes five modules mapped from 0xda, 0xe0 and 0xe8.
module wave_array_props #(
   parameter int NMOD = 5
) (
   input wire logic               core_clk,
   input wire logic               sys_rst,
   input wire wave_pkg::sfr_req_s sfr_req,
   input wire logic               timer0_ovf,
   input wire logic [7:0]         sfr_rdata,
   input wire logic [NMOD-1:0]    module_output_pin
);
   logic       run_q;
   logic [2:0] tb_hi_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Run bit as last written; the flags never touch it
   always_ff @(posedge core_clk) begin
      if (sys_rst) run_q <= 1'b0;
      else if (sfr_req.wr && sfr_req.addr == 8'hd8) run_q <= sfr_req.wdata[6];
   end
   // Unused mode bits leave reset as 100 and read zero after any write
   always_ff @(posedge core_clk) begin
      if (sys_rst) tb_hi_q <= 3'h4;
      else if (sfr_req.wr && sfr_req.addr == 8'hd9) tb_hi_q <= 3'h0;
   end
   // ****
   // Properties
   // ****
   property p_rst; $fell(sys_rst) |-> module_output_pin == '0 && sfr_rdata == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear after reset");
   property p_low_wr; sfr_req.wr && sfr_req.addr == 8'he0 ##2 sfr_req.rd && sfr_req.addr == 8'hda
      |=> !sfr_rdata[6]; endproperty
   a_low_wr: assert property (p_low_wr) else $error("enable kept after low write");
   property p_high_wr; sfr_req.wr && sfr_req.addr == 8'he8 ##2 sfr_req.rd && sfr_req.addr == 8'hda
      |=> sfr_rdata[6]; endproperty
   a_high_wr: assert property (p_high_wr) else $error("enable not set by high write");
   // Pins may still settle two cycles after a register write
   property p_frozen; !run_q && !sfr_req.wr && !$past(sfr_req.wr) |=> $stable(module_output_pin); endproperty
   a_frozen: assert property (p_frozen) else $error("pin moved while stopped");
   property p_run; sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'hd8 |=> sfr_rdata[6] == run_q; endproperty
   a_run: assert property (p_run) else $error("run bit readback");
   property p_tb; sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'hd9 |=> sfr_rdata[6:4] == tb_hi_q; endproperty
   a_tb: assert property (p_tb) else $error("unused mode bits wrong");
   property p_bit5; sfr_req.rd && sfr_req.addr == 8'hd8 |=> !sfr_rdata[5]; endproperty
   a_bit5: assert property (p_bit5) else $error("unused flag bit set");
   property p_unmap; sfr_req.rd && !(sfr_req.addr inside {[8'hd8:8'hde], [8'he0:8'he4], [8'he8:8'hec]})
      |=> sfr_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind wave_array wave_array_props #(.NMOD(NMOD)) wave_array_props_i (.core_clk(core_clk), .sys_rst(sys_rst),
   .sfr_req(sfr_req), .timer0_ovf(timer0_ovf), .sfr_rdata(sfr_rdata), .module_output_pin(module_output_pin));

// ==== tb/wave_load.sv ====
// Load on the module pins: counts high cycles and level changes.
// Assumes one sample per rising core_clk edge; clr zeroes the counts.
module wave_load (
   input  wire logic       core_clk,
   input  wire logic       clr,
   input  wire logic [4:0] pin,
   output int              hi[5],
   output int              tg[5]
);
   logic [4:0] prev;
   always_ff @(posedge core_clk) begin
      prev <= pin;
      for (int i = 0; i < 5; i++) begin
         hi[i] <= clr ? 0 : hi[i] + int'(pin[i]);
         tg[i] <= clr ? 0 : tg[i] + int'(pin[i] != prev[i]);
      end
   end
endmodule

// ==== tb/test_counter_array_waveform_output.sv ====
// Bench for the waveform block: register rows, then all modes at once.
// Assumes the system clock timebase ticks the counter every cycle.
module test_counter_array_waveform_output;
   timeunit 1ns;
   timeprecision 100ps;
   logic               core_clk = 1'b0;
   logic               sys_rst = 1'b1;
   logic               clr = 1'b1;
   logic               t0_en = 1'b0;
   logic               t0_ovf = 1'b0;
   wave_pkg::sfr_req_s sfr_req = '0;
   logic [7:0]         sfr_rdata;
   logic [4:0]         module_output_pin;
   logic [4:0]         held;
   int                 hi[5];
   int                 tg[5];
   int                 mismatches = 0;
   int                 compares = 0;
   int                 cycles = 0;
   logic [7:0]         rows[6][4] = '{'{8'hd9, 8'hff, 8'hd9, 8'h8f}, '{8'hda, 8'h42, 8'hda, 8'h42},
      '{8'he0, 8'h10, 8'hda, 8'h02}, '{8'he8, 8'h80, 8'hda, 8'h42}, '{8'hc0, 8'h5a, 8'hc0, 8'h00},
      '{8'hd9, 8'h08, 8'he0, 8'h10}};
   // Modules 1 to 4: short square wave, 256 half period, 16-bit pulse, disabled pulse
   logic [7:0]         cfg[12][2] = '{'{8'hdb, 8'h46}, '{8'he1, 8'h00}, '{8'he9, 8'h10}, '{8'hdc, 8'h46},
      '{8'he2, 8'h00}, '{8'hea, 8'h00}, '{8'hdd, 8'hc2}, '{8'he3, 8'h00}, '{8'heb, 8'hc0}, '{8'hde, 8'h42},
      '{8'hec, 8'h10}, '{8'he4, 8'h40}};
   always #2.5 core_clk = ~core_clk;
   // Timer overflow pulses every other cycle once enabled
   always @(negedge core_clk) t0_ovf = t0_en & ~t0_ovf;
   wave_array wave_array_i (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_req(sfr_req), .timer0_ovf(t0_ovf),
      .sfr_rdata(sfr_rdata), .module_output_pin(module_output_pin));
   wave_load wave_load_i (.core_clk(core_clk), .clr(clr), .pin(module_output_pin), .hi(hi), .tg(tg));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk) sfr_req = '{1'b1, 1'b0, a, d};
      @(negedge core_clk) sfr_req = '0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk) sfr_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge core_clk) sfr_req = '0;
      chk(sfr_rdata, e);
   endtask
   // Module 1 toggles every 16 ticks; count its toggles under another timebase
   task automatic rate(input logic [7:0] code, input int len, input int exp);
      clr = 1'b1;
      wr(8'hd9, code);
      repeat (400) @(negedge core_clk);
      clr = 1'b0;
      repeat (len) @(negedge core_clk);
      chk(tg[1], exp);
   endtask
   task automatic finish_test;
      if (mismatches == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         finish_test();
      end
   end
   // ****
   // Sequence
   // ****
   initial begin
      repeat (3) @(negedge core_clk);
      sys_rst = 1'b0;
      chk(module_output_pin, 5'h0);
      rc(8'hd8, 8'h00);
      rc(8'hd9, 8'h40);
      foreach (rows[i]) begin
         wr(rows[i][0], rows[i][1]);
         rc(rows[i][2], rows[i][3]);
      end
      foreach (cfg[i]) wr(cfg[i][0], cfg[i][1]);
      wr(8'hd8, 8'h40);
      // Skip the first partial periods; the window is a whole number of every period
      repeat (600) @(negedge core_clk);
      clr = 1'b0;
      repeat (65536) @(negedge core_clk);
      chk(hi[0], 32768);
      chk(tg[1], 4096);
      chk(tg[2], 256);
      chk(hi[3], 16384);
      chk(hi[4], 0);
      rc(8'hd8, 8'hcf);
      wr(8'hd8, 8'h00);
      repeat (2) @(negedge core_clk);
      held = module_output_pin;
      repeat (40) @(negedge core_clk);
      chk(module_output_pin, held);
      wr(8'hd8, 8'h40);
      rate(8'h02, 4096, 64);
      rate(8'h00, 3072, 16);
      t0_en = 1'b1;
      rate(8'h04, 2048, 64);
      finish_test();
   end
endmodule
